/* uhe_pkg.sv */
// Constants, encodings and register map for the home event selector.
// Assumes a single 25 MHz system clock and an APB master for software.
// How it works
// - The line-allocation event counts allocated lines with mask bits 01 M, 02 E, 04 S, 08 F.
// - A line is allocated in M only when it arrived forwarded in M for a read-invalidate-own snoop.
// - The line-allocation event with all four state bits counts every allocation.
// - The victim event counts evicted lines by prior state with bits 01 M, 02 E, 04 S, 08 I, 10 F.
// - A victim line in M is written back to its home agent, local or remote.
// - The victim event with all five state bits counts every victimized line.
// - The home request event counts io hub reads under 01 and io hub writes under 02.
// - The home request event counts remote reads under 04 and remote writes under 08.
// - The home request event counts local reads under 10 and local writes under 20.
// - The tracker-full event adds one per cycle the io hub (01) or remote (02) tracker is full.
// - The tracker-full event with mask 04 adds one per cycle the local tracker is full.
// - The tracker-busy event counts cycles a tracker is busy: 01 io hub, 02 remote, 04 local.
package uhe_pkg;

	// Event codes
	localparam logic [7:0] EVT_LINE_ALLOC = 8'h0a;
	localparam logic [7:0] EVT_LINE_VICT  = 8'h0b;
	localparam logic [7:0] EVT_HOME_REQ   = 8'h20;
	localparam logic [7:0] EVT_TRK_FULL   = 8'h21;
	localparam logic [7:0] EVT_TRK_BUSY   = 8'h22;

	// Line states on the allocation side; code is the mask bit index
	typedef enum logic [1:0] {
		ALLOC_M = 2'h0,
		ALLOC_E = 2'h1,
		ALLOC_S = 2'h2,
		ALLOC_F = 2'h3
	} uhe_alloc_e;

	// Prior state of a victim; code is the mask bit index
	typedef enum logic [2:0] {
		VICT_M = 3'h0,
		VICT_E = 3'h1,
		VICT_S = 3'h2,
		VICT_I = 3'h3,
		VICT_F = 3'h4
	} uhe_vict_e;

	// Request source; mask bit index is source * 2 + write
	typedef enum logic [1:0] {
		SRC_IO     = 2'h0,
		SRC_REMOTE = 2'h1,
		SRC_LOCAL  = 2'h2
	} uhe_src_e;

	localparam int unsigned NUM_TRK   = 3;
	localparam int unsigned OCC_W     = 5;
	localparam logic [4:0]  TRK_DEPTH = 5'h10;
	localparam int unsigned NUM_CNT   = 2;
	localparam int unsigned CNT_W     = 32;
	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned LINE_W    = 32;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL0  = 12'h000;
	localparam logic [11:0] OFF_COUNT0 = 12'h004;
	localparam logic [11:0] OFF_CTRL1  = 12'h008;
	localparam logic [11:0] OFF_COUNT1 = 12'h00c;
	localparam logic [11:0] OFF_STATUS = 12'h010;

	// Control register fields
	localparam int unsigned CTRL_EVT_LSB  = 0;
	localparam int unsigned CTRL_MASK_LSB = 8;
	localparam int unsigned CTRL_EN_BIT   = 22;
	localparam logic [31:0] CTRL_RW_MASK  = 32'h0040ffff;
	localparam logic [31:0] CTRL_RESET    = 32'h00000000;
	localparam logic [31:0] COUNT_RESET   = 32'h00000000;

	// Status fields: full bits, busy bits, write-back pending
	localparam int unsigned STAT_FULL_LSB = 0;
	localparam int unsigned STAT_BUSY_LSB = 4;
	localparam int unsigned STAT_WB_BIT   = 8;

endpackage : uhe_pkg

/* uhe_evt_counter.sv */
// One event counter slot: event match, mask qualify, count.
// Assumes condition vectors already aligned to mask bit positions.
`timescale 1ns/100ps
module uhe_evt_counter (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic [7:0]               evt_code_i,
	input  wire logic [7:0]               umask_i,
	input  wire logic                     en_i,
	input  wire logic [7:0]               alloc_vec_i,
	input  wire logic [7:0]               vict_vec_i,
	input  wire logic [7:0]               req_vec_i,
	input  wire logic [7:0]               full_vec_i,
	input  wire logic [7:0]               busy_vec_i,
	input  wire logic                     wr_i,
	input  wire logic [uhe_pkg::CNT_W-1:0] wr_data_i,
	output logic      [uhe_pkg::CNT_W-1:0] count_o
);

	logic [7:0]               sel_vec;
	logic                     hit;
	logic [uhe_pkg::CNT_W-1:0] count_d;
	logic [uhe_pkg::CNT_W-1:0] count_q;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (evt_code_i)
			uhe_pkg::EVT_LINE_ALLOC: sel_vec = alloc_vec_i;
			uhe_pkg::EVT_LINE_VICT:  sel_vec = vict_vec_i;
			uhe_pkg::EVT_HOME_REQ:   sel_vec = req_vec_i;
			uhe_pkg::EVT_TRK_FULL:   sel_vec = full_vec_i;
			uhe_pkg::EVT_TRK_BUSY:   sel_vec = busy_vec_i;
			default:                 sel_vec = 8'h00;
		endcase
		// Union of all enabled bits, so the any-state masks cover all
		hit = en_i && (|(sel_vec & umask_i));
		count_d = count_q;
		// Software load beats a same-cycle increment
		if (wr_i) begin
			count_d = wr_data_i;
		end else if (hit) begin
			count_d = count_q + {{(uhe_pkg::CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= uhe_pkg::COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_o = count_q;

endmodule : uhe_evt_counter

/* uhe_event_top.sv */
// Home and last-level cache event selector with two APB counters.
// Assumes all event inputs come from logic on clk_sys_i.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module uhe_event_top (
	input  wire logic                       clk_sys_i,
	input  wire logic                       arst_n_i,
	// APB slave
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [uhe_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]                pwdata_i,
	output logic      [31:0]                prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	// Line allocation request
	input  wire logic                       alloc_valid_i,
	input  wire logic [1:0]                 alloc_state_i,
	input  wire logic                       alloc_fwd_rfo_i,
	output logic                            alloc_done_o,
	output logic      [1:0]                 alloc_state_o,
	// Victim lines
	input  wire logic                       vict_valid_i,
	input  wire logic [2:0]                 vict_state_i,
	input  wire logic [uhe_pkg::LINE_W-1:0] vict_addr_i,
	input  wire logic                       vict_home_remote_i,
	output logic                            vict_ready_o,
	// Write-back to home agent
	output logic                            wb_valid_o,
	output logic      [uhe_pkg::LINE_W-1:0] wb_addr_o,
	output logic                            wb_remote_o,
	input  wire logic                       wb_ready_i,
	// Home logic requests
	input  wire logic                       req_valid_i,
	input  wire logic [1:0]                 req_src_i,
	input  wire logic                       req_write_i,
	// Tracker occupancy: io hub, remote, local
	input  wire logic [uhe_pkg::OCC_W-1:0]  occ_io_i,
	input  wire logic [uhe_pkg::OCC_W-1:0]  occ_remote_i,
	input  wire logic [uhe_pkg::OCC_W-1:0]  occ_local_i
);

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_d;
	logic rst_meta_q;
	logic rst_n_d;
	logic rst_n_q;

	// Async assert, sync release: no flop leaves reset mid-cycle
	always_comb begin
		rst_meta_d = 1'b1;
		rst_n_d    = rst_meta_q;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= rst_meta_d;
			rst_n_q    <= rst_n_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line allocation
	logic       alloc_done_d;
	logic       alloc_done_q;
	logic [1:0] alloc_state_d;
	logic [1:0] alloc_state_q;
	logic [7:0] alloc_vec;

	always_comb begin
		alloc_done_d  = alloc_valid_i;
		alloc_state_d = alloc_state_q;
		alloc_vec     = 8'h00;
		if (alloc_valid_i) begin
			alloc_state_d = alloc_state_i;
			// M only via forwarded M on read-invalidate-own; else E
			if (alloc_state_i == uhe_pkg::ALLOC_M && !alloc_fwd_rfo_i) begin
				alloc_state_d = uhe_pkg::ALLOC_E;
			end
			// Count the state actually entered
			alloc_vec = 8'h01 << alloc_state_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			alloc_done_q  <= 1'b0;
			alloc_state_q <= uhe_pkg::ALLOC_E;
		end else begin
			alloc_done_q  <= alloc_done_d;
			alloc_state_q <= alloc_state_d;
		end
	end

	assign alloc_done_o  = alloc_done_q;
	assign alloc_state_o = alloc_state_q;

	////////////////////////////////////////////////////////////////////////
	// Victims and write-back
	typedef enum logic [0:0] {
		WB_IDLE = 1'h0,
		WB_BUSY = 1'h1
	} uhe_wb_e;

	uhe_wb_e                      wb_st_d;
	uhe_wb_e                      wb_st_q;
	logic [uhe_pkg::LINE_W-1:0]   wb_addr_d;
	logic [uhe_pkg::LINE_W-1:0]   wb_addr_q;
	logic                         wb_remote_d;
	logic                         wb_remote_q;
	logic                         vict_take;
	logic [7:0]                   vict_vec;

	// One write-back outstanding; victims stall until it drains
	assign vict_ready_o = (wb_st_q == WB_IDLE);
	assign vict_take    = vict_valid_i && vict_ready_o;

	always_comb begin
		wb_st_d     = wb_st_q;
		wb_addr_d   = wb_addr_q;
		wb_remote_d = wb_remote_q;
		// Counted on acceptance, so a stalled victim counts once
		vict_vec    = vict_take ? (8'h01 << vict_state_i) : 8'h00;
		case (wb_st_q)
			WB_IDLE: begin
				if (vict_take && vict_state_i == uhe_pkg::VICT_M) begin
					wb_st_d     = WB_BUSY;
					wb_addr_d   = vict_addr_i;
					wb_remote_d = vict_home_remote_i;
				end
			end
			WB_BUSY: begin
				if (wb_ready_i) begin
					wb_st_d = WB_IDLE;
				end
			end
			default: begin
				wb_st_d = WB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wb_st_q     <= WB_IDLE;
			wb_addr_q   <= {uhe_pkg::LINE_W{1'b0}};
			wb_remote_q <= 1'b0;
		end else begin
			wb_st_q     <= wb_st_d;
			wb_addr_q   <= wb_addr_d;
			wb_remote_q <= wb_remote_d;
		end
	end

	assign wb_valid_o  = (wb_st_q == WB_BUSY);
	assign wb_addr_o   = wb_addr_q;
	assign wb_remote_o = wb_remote_q;

	////////////////////////////////////////////////////////////////////////
	// Home requests and trackers
	logic [7:0]                 req_vec;
	logic [7:0]                 full_vec;
	logic [7:0]                 busy_vec;
	logic [uhe_pkg::NUM_TRK-1:0] trk_full;
	logic [uhe_pkg::NUM_TRK-1:0] trk_busy;
	logic [2:0]                 req_idx;

	assign req_idx = {req_src_i, req_write_i};

	always_comb begin
		req_vec = 8'h00;
		// Source 3 is not a tracker and counts nowhere
		if (req_valid_i && req_src_i != 2'h3) begin
			req_vec = 8'h01 << req_idx;
		end
	end

	// Tracker index io, remote, local matches the source codes
	logic [uhe_pkg::OCC_W-1:0] occ [uhe_pkg::NUM_TRK];

	assign occ[0] = occ_io_i;
	assign occ[1] = occ_remote_i;
	assign occ[2] = occ_local_i;

	for (genvar t = 0; t < uhe_pkg::NUM_TRK; t++) begin : g_trk
		assign trk_full[t] = (occ[t] == uhe_pkg::TRK_DEPTH);
		assign trk_busy[t] = |occ[t];
	end
	assign full_vec = {5'h00, trk_full};
	assign busy_vec = {5'h00, trk_busy};

	////////////////////////////////////////////////////////////////////////
	// APB registers
	logic [31:0] ctrl_q [uhe_pkg::NUM_CNT];
	logic [31:0] ctrl_d [uhe_pkg::NUM_CNT];
	logic [31:0] count  [uhe_pkg::NUM_CNT];
	logic        cnt_wr [uhe_pkg::NUM_CNT];
	logic        setup;
	logic        access_wr;
	logic [31:0] rd_mux;
	logic        err_mux;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;
	logic        pslverr_d;
	logic        pslverr_q;
	logic [31:0] status;

	assign setup     = psel_i && !penable_i;
	assign access_wr = psel_i && penable_i && pwrite_i;

	// Live view, sampled at setup like every other read
	always_comb begin
		status = 32'h00000000;
		status[uhe_pkg::STAT_FULL_LSB +: uhe_pkg::NUM_TRK] = trk_full;
		status[uhe_pkg::STAT_BUSY_LSB +: uhe_pkg::NUM_TRK] = trk_busy;
		status[uhe_pkg::STAT_WB_BIT] = wb_valid_o;
	end

	always_comb begin
		rd_mux  = 32'h00000000;
		err_mux = 1'b0;
		case (paddr_i)
			uhe_pkg::OFF_CTRL0:  rd_mux = ctrl_q[0];
			uhe_pkg::OFF_COUNT0: rd_mux = count[0];
			uhe_pkg::OFF_CTRL1:  rd_mux = ctrl_q[1];
			uhe_pkg::OFF_COUNT1: rd_mux = count[1];
			uhe_pkg::OFF_STATUS: begin
				rd_mux  = status;
				err_mux = pwrite_i;
			end
			default:             err_mux = 1'b1;
		endcase
		// Data and error latched at setup, presented in access phase
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		if (setup) begin
			prdata_d  = pwrite_i ? 32'h00000000 : rd_mux;
			pslverr_d = err_mux;
		end
	end

	always_comb begin
		for (int i = 0; i < uhe_pkg::NUM_CNT; i++) begin
			ctrl_d[i] = ctrl_q[i];
			cnt_wr[i] = 1'b0;
		end
		if (access_wr) begin
			case (paddr_i)
				uhe_pkg::OFF_CTRL0:  ctrl_d[0] = pwdata_i & uhe_pkg::CTRL_RW_MASK;
				uhe_pkg::OFF_CTRL1:  ctrl_d[1] = pwdata_i & uhe_pkg::CTRL_RW_MASK;
				uhe_pkg::OFF_COUNT0: cnt_wr[0] = 1'b1;
				uhe_pkg::OFF_COUNT1: cnt_wr[1] = 1'b1;
				default:             ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < uhe_pkg::NUM_CNT; i++) begin
				ctrl_q[i] <= uhe_pkg::CTRL_RESET;
			end
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			for (int i = 0; i < uhe_pkg::NUM_CNT; i++) begin
				ctrl_q[i] <= ctrl_d[i];
			end
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Zero wait states
	assign pready_o  = 1'b1;
	assign prdata_o  = prdata_q;
	assign pslverr_o = pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// Counter slots
	for (genvar g = 0; g < uhe_pkg::NUM_CNT; g++) begin : g_cnt
		uhe_evt_counter u_cnt (
			.clk_i       (clk_sys_i),
			.rst_n_i     (rst_n_q),
			.evt_code_i  (ctrl_q[g][uhe_pkg::CTRL_EVT_LSB +: 8]),
			.umask_i     (ctrl_q[g][uhe_pkg::CTRL_MASK_LSB +: 8]),
			.en_i        (ctrl_q[g][uhe_pkg::CTRL_EN_BIT]),
			.alloc_vec_i (alloc_vec),
			.vict_vec_i  (vict_vec),
			.req_vec_i   (req_vec),
			.full_vec_i  (full_vec),
			.busy_vec_i  (busy_vec),
			.wr_i        (cnt_wr[g]),
			.wr_data_i   (pwdata_i),
			.count_o     (count[g])
		);
	end

endmodule : uhe_event_top

/* uhe_event_assertions.sv */
// Port checker for uhe_event_top, bound onto every instance.
// Assumes the top's async reset; inner sync lag is covered by idle inputs.
`timescale 1ns/100ps
module uhe_event_chk (
	input wire logic        clk_sys_i,
	input wire logic        arst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        alloc_valid_i,
	input wire logic [1:0]  alloc_state_i,
	input wire logic        alloc_fwd_rfo_i,
	input wire logic        alloc_done_o,
	input wire logic [1:0]  alloc_state_o,
	input wire logic        vict_valid_i,
	input wire logic [2:0]  vict_state_i,
	input wire logic [31:0] vict_addr_i,
	input wire logic        vict_home_remote_i,
	input wire logic        vict_ready_o,
	input wire logic        wb_valid_o,
	input wire logic [31:0] wb_addr_o,
	input wire logic        wb_remote_o,
	input wire logic        wb_ready_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////////
	sequence s_vict_m;
		vict_valid_i && vict_ready_o && vict_state_i == 3'h0;
	endsequence
	sequence s_wb_up;
		wb_valid_o && wb_addr_o == $past(vict_addr_i)
			&& wb_remote_o == $past(vict_home_remote_i);
	endsequence
	sequence s_m_req;
		alloc_valid_i && alloc_state_i == 2'h0;
	endsequence
	////////////////////////////////////////////////////////////////////
	chk_done_pulse: assert property (alloc_valid_i |=> alloc_done_o)
		else $error("alloc done missing");
	chk_done_quiet: assert property (!alloc_valid_i |=> !alloc_done_o)
		else $error("alloc done without request");
	chk_m_demote: assert property (s_m_req ##0 !alloc_fwd_rfo_i |=>
		alloc_state_o == 2'h1) else $error("M entered without forward");
	chk_m_keep: assert property (s_m_req ##0 alloc_fwd_rfo_i |=>
		alloc_state_o == 2'h0) else $error("forwarded M not kept");
	chk_state_pass: assert property (alloc_valid_i && alloc_state_i != 2'h0
		|=> alloc_state_o == $past(alloc_state_i)) else $error("bad state");
	chk_state_hold: assert property (!alloc_valid_i |=> $stable(alloc_state_o))
		else $error("alloc state moved");
	chk_wb_launch: assert property (s_vict_m |=> s_wb_up)
		else $error("write-back not launched");
	chk_wb_hold: assert property (wb_valid_o && !wb_ready_i |=>
		wb_valid_o && $stable(wb_addr_o)) else $error("write-back dropped");
	chk_wb_stall: assert property (wb_valid_o |-> !vict_ready_o)
		else $error("victim taken during write-back");
	chk_wb_none: assert property (vict_valid_i && vict_ready_o
		&& vict_state_i != 3'h0 |=> !wb_valid_o) else $error("spurious wb");
	chk_wb_drop: assert property (wb_valid_o && wb_ready_i |=> !wb_valid_o)
		else $error("write-back not retired");
	chk_bad_addr: assert property (psel_i && !penable_i && paddr_i >= 12'h014
		|=> pslverr_o) else $error("unmapped address not refused");
	chk_ready_zero: assert property (psel_i && penable_i |-> pready_o)
		else $error("wait state inserted");
	chk_stat_wr: assert property (psel_i && !penable_i && pwrite_i
		&& paddr_i == 12'h010 |=> pslverr_o)
		else $error("status write not refused");
	chk_good_addr: assert property (psel_i && !penable_i && !pwrite_i
		&& paddr_i <= 12'h010 && paddr_i[1:0] == 2'h0 |=> !pslverr_o)
		else $error("mapped read refused");
endmodule : uhe_event_chk

bind uhe_event_top uhe_event_chk uhe_event_chk_inst (
	.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .alloc_valid_i(alloc_valid_i),
	.alloc_state_i(alloc_state_i), .alloc_fwd_rfo_i(alloc_fwd_rfo_i),
	.alloc_done_o(alloc_done_o), .alloc_state_o(alloc_state_o),
	.vict_valid_i(vict_valid_i), .vict_state_i(vict_state_i),
	.vict_addr_i(vict_addr_i), .vict_home_remote_i(vict_home_remote_i),
	.vict_ready_o(vict_ready_o), .wb_valid_o(wb_valid_o),
	.wb_addr_o(wb_addr_o), .wb_remote_o(wb_remote_o),
	.wb_ready_i(wb_ready_i));

/* tb.sv */
// Self-checking bench for uhe_event_top over APB.
// Assumes zero-wait APB reads, checked from a queue of expected words.
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, vaddr = 32'h0, wba;
	logic        pready, pslverr, adone, vrdy, wbv, wbr;
	logic        av = 1'b0, afw = 1'b0, vv = 1'b0, vrem = 1'b0;
	logic        wbrdy = 1'b0, rv = 1'b0, rw = 1'b0;
	logic [1:0]  ast = 2'h0, aso, rsrc = 2'h0;
	logic [2:0]  vst = 3'h0;
	logic [4:0]  occ [3] = '{5'h0, 5'h0, 5'h0};
	logic [31:0] exp_q [$];
	int          fails = 0, n_compared = 0;

	uhe_event_top uhe_event_top_inst (
		.clk_sys_i(clk), .arst_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .alloc_valid_i(av), .alloc_state_i(ast),
		.alloc_fwd_rfo_i(afw), .alloc_done_o(adone),
		.alloc_state_o(aso), .vict_valid_i(vv), .vict_state_i(vst),
		.vict_addr_i(vaddr), .vict_home_remote_i(vrem),
		.vict_ready_o(vrdy), .wb_valid_o(wbv), .wb_addr_o(wba),
		.wb_remote_o(wbr), .wb_ready_i(wbrdy), .req_valid_i(rv),
		.req_src_i(rsrc), .req_write_i(rw), .occ_io_i(occ[0]),
		.occ_remote_i(occ[1]), .occ_local_i(occ[2]));

	always #20 clk = ~clk;
	// Random accept stalls the write-back path
	always @(posedge clk) wbrdy <= 1'($urandom);
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] e);
		n_compared++;
		if (seen !== e) begin
			fails++;
			$display("Error t=%0t seen %h exp %h", $time, seen, e);
		end
	endtask : check

	always @(posedge clk)
		if (psel && pen && pready === 1'b1 && !pwr)
			check(prdata, exp_q.pop_front());

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////
	// Each task ends one edge after release, so no double drive
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic cnt(input bit i, input logic [31:0] e);
		rd(i ? uhe_pkg::OFF_COUNT1 : uhe_pkg::OFF_COUNT0, e);
	endtask : cnt

	task automatic sel(input logic [7:0] e, input logic [7:0] m);
		apb(1'b1, uhe_pkg::OFF_CTRL1, 32'h00400000 | {16'h0, m, e});
		apb(1'b1, uhe_pkg::OFF_COUNT1, 32'h0);
	endtask : sel

	task automatic alloc(input logic [1:0] s, input logic f);
		av <= 1'b1;
		ast <= s;
		afw <= f;
		@(posedge clk);
		av <= 1'b0;
		@(posedge clk);
	endtask : alloc

	task automatic req(input logic [1:0] s, input logic w);
		rv <= 1'b1;
		rsrc <= s;
		rw <= w;
		@(posedge clk);
		rv <= 1'b0;
		@(posedge clk);
	endtask : req

	task automatic vict(input logic [2:0] s);
		vv <= 1'b1;
		vst <= s;
		vaddr <= $urandom;
		vrem <= 1'($urandom);
		do @(posedge clk); while (vrdy !== 1'b1);
		vv <= 1'b0;
		@(posedge clk);
	endtask : vict

	// One mask bit at a time; every condition fired once
	task automatic sweep(input logic [7:0] e, input int n);
		for (int i = 0; i < n; i++) begin
			sel(e, 8'h1 << i);
			for (int s = 0; s < n; s++)
				case (e)
					8'h0a: alloc(2'(s), 1'b1);
					8'h0b: vict(3'(s));
					default: req(2'(s >> 1), 1'(s));
				endcase
			cnt(1'b1, 32'h1);
		end
	endtask : sweep
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		complete_run();
	end

	initial begin
		int          n;
		logic [4:0]  v;
		logic [31:0] st;
		void'($urandom(70981));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(uhe_pkg::OFF_CTRL0, uhe_pkg::CTRL_RESET);
		cnt(1'b1, uhe_pkg::COUNT_RESET);
		apb(1'b1, uhe_pkg::OFF_CTRL1, 32'hffffffff);
		rd(uhe_pkg::OFF_CTRL1, uhe_pkg::CTRL_RW_MASK);
		// Unknown event code counts nothing
		alloc(2'h1, 1'b0);
		req(2'h0, 1'b0);
		cnt(1'b1, 32'h0);
		// Status is read-only and idle here
		apb(1'b1, uhe_pkg::OFF_STATUS, 32'hffffffff);
		rd(uhe_pkg::OFF_STATUS, 32'h0);
		rd(12'h020, 32'h0);
		apb(1'b1, uhe_pkg::OFF_CTRL0, 32'h00400f0a);
		sel(8'h0a, 8'h02);
		alloc(2'h0, 1'b0);
		for (int s = 0; s < 4; s++)
			alloc(2'(s), 1'b1);
		cnt(1'b0, 32'h5);
		cnt(1'b1, 32'h2);
		apb(1'b1, uhe_pkg::OFF_CTRL0, 32'h00401f0b);
		apb(1'b1, uhe_pkg::OFF_COUNT0, 32'h0);
		for (int s = 0; s < 5; s++)
			vict(3'(s));
		cnt(1'b0, 32'h5);
		sweep(8'h0a, 4);
		sweep(8'h0b, 5);
		sweep(8'h20, 6);
		// Source 3 counts nowhere, even under all six defined mask bits (3f)
		sel(8'h20, 8'h3f);
		req(2'h3, 1'b0);
		req(2'h3, 1'b1);
		req(2'h2, 1'b1);
		cnt(1'b1, 32'h1);
		for (int e = 0; e < 2; e++)
			for (int k = 0; k < 3; k++) begin
				n = 1 + $urandom % 20;
				v = 5'(1 + $urandom % 16);
				sel(8'h21 + 8'(e), 8'h1 << k);
				for (int j = 0; j < 3; j++)
					occ[j] <= (j != k) ? (e ? 5'h0 : 5'h0f)
						: (e ? v : 5'h10);
				if (e)
					st = (32'h1 << (uhe_pkg::STAT_BUSY_LSB + k))
						| ((v == 5'h10)
						? (32'h1 << (uhe_pkg::STAT_FULL_LSB + k)) : 32'h0);
				else
					st = (32'h7 << uhe_pkg::STAT_BUSY_LSB)
						| (32'h1 << (uhe_pkg::STAT_FULL_LSB + k));
				// Status read spans three counted cycles
				rd(uhe_pkg::OFF_STATUS, st);
				repeat (n) @(posedge clk);
				for (int j = 0; j < 3; j++)
					occ[j] <= 5'h0;
				@(posedge clk);
				cnt(1'b1, 32'(n + 3));
			end
		complete_run();
	end
endmodule : tb
